// >>> design/margin_pkg.sv
// Constants and types shared by the supply margining controller
// Behaviour
// - Setup slope bit picks whether raising drive lowers or raises output
// - Open-loop bit holds drive at initial value while margining; DAC pages first spend one cycle at drive zero
// - Setup bits 13:8 always read back as zero
// - Initial drive field sets starting duty, or constant drive in open loop
// - DAC-driven pages start from drive value zero automatically
// - After margin off with faults ignored, monitoring waits a fixed delay
// - Fault when the first step already passes the sought target
// - Fault when drive sits at the zero or full-scale rail that the next step heads for, with target unmet
// - After a margining fault the adjustment loop keeps running
// - Fault sets status margin bit, page fault flag, and alert if enabled
// - DAC link failure shows as fault at zero or full scale with target unmet
// - Margin high sinks feedback current, margin low sources it
// - PWM runs at fixed frequency; outputs high impedance when inactive
// - Margining starts only once all monitored channels are power good
// - Closed loop averages four samples per window, then steps once
package margin_pkg;

    localparam logic [7:0]  MARGIN_SETUP_CODE  = 8'hDF;
    localparam logic [15:0] MARGIN_SETUP_RESET = 16'h0000;
    localparam int          SLOPE_BIT          = 15;
    localparam int          OPEN_LOOP_BIT      = 14;
    localparam int          INIT_MSB           = 7;
    localparam logic [15:0] SETUP_WRITE_MASK   = 16'hC0FF;

    localparam int          CLOCK_HZ           = 250_000_000;
    localparam int          PWM_FREQ_HZ        = 312_500;
    localparam int          PWM_PERIOD_CYCLES  = CLOCK_HZ / PWM_FREQ_HZ;
    localparam int          WINDOW_MS          = 20;
    localparam int          WINDOW_CYCLES      = CLOCK_HZ / 1000 * WINDOW_MS;
    localparam int          HOLDOFF_MS         = 100;
    localparam int          HOLDOFF_CYCLES     = CLOCK_HZ / 1000 * HOLDOFF_MS;

    localparam int          SAMPLES_PER_WINDOW = 4;
    localparam int          AVG_SHIFT          = 2;
    localparam logic [7:0]  DRIVE_MIN          = 8'h00;
    localparam logic [7:0]  DRIVE_MAX          = 8'hFF;
    localparam logic [7:0]  DAC_INITIAL_DRIVE  = 8'h00;

    typedef enum logic [1:0] {
        CMD_OFF,
        CMD_HIGH,
        CMD_LOW
    } margin_cmd_t;

    typedef enum logic [1:0] {
        ST_IDLE,
        ST_WAIT_PG,
        ST_MARGIN
    } margin_state_t;

endpackage : margin_pkg

// >>> design/supply_margining_controller.sv
// Closed-loop margining controller for one supply page
`timescale 1ns/1ps
module supply_margining_controller
    import margin_pkg::*;
#(
    parameter int VOUT_W         = 16,
    parameter int WINDOW_COUNT   = WINDOW_CYCLES,
    parameter int HOLDOFF_COUNT  = HOLDOFF_CYCLES
) (
    input  wire logic              clock_in,          // 250 MHz clock
    input  wire logic              rst_n_in,          // Async reset, low
    input  wire logic              reg_wr_in,         // Register write strobe
    input  wire logic              reg_rd_in,         // Register read strobe
    input  wire logic [7:0]        reg_code_in,       // Command code
    input  wire logic [15:0]       reg_wdata_in,      // Write data
    input  wire logic [1:0]        margin_cmd_in,     // Off, high or low
    input  wire logic              ignore_faults_in,  // Ignore-all-faults mode
    input  wire logic              power_good_all_in, // All channels good
    input  wire logic              dac_page_in,       // Page uses current DAC
    input  wire logic [VOUT_W-1:0] vout_sample_in,    // Measured output
    input  wire logic              sample_valid_in,   // Sample strobe
    input  wire logic [VOUT_W-1:0] target_high_in,    // Margin-high target
    input  wire logic [VOUT_W-1:0] target_low_in,     // Margin-low target
    input  wire logic              alert_enable_in,   // Alert enabled
    input  wire logic              status_clear_in,   // Clear fault flags
    output logic [15:0]            reg_rdata_out,     // Read data
    output logic                   reg_rvalid_out,    // Read data valid
    output logic                   margin_pulse_out,  // PWM level
    output logic                   pulse_oe_out,      // PWM pin driven
    output logic [7:0]             dac_value_out,     // Drive value
    output logic                   dac_oe_out,        // DAC output enabled
    output logic                   sink_current_out,  // 1 sink, 0 source
    output logic                   status_margin_out, // Status word bit
    output logic                   margin_fault_out,  // Page fault flag
    output logic                   alert_out,         // Alert request
    output logic                   fault_monitor_out  // Fault monitoring on
);

    localparam int PCNT_W = $clog2(PWM_PERIOD_CYCLES);
    localparam int WCNT_W = $clog2(WINDOW_COUNT + 1);
    localparam int HCNT_W = $clog2(HOLDOFF_COUNT + 1);
    localparam int SUM_W  = VOUT_W + AVG_SHIFT;
    localparam int NS_W   = $clog2(SAMPLES_PER_WINDOW + 1);
    localparam logic [PCNT_W-1:0] PCNT_LAST =
        PCNT_W'(PWM_PERIOD_CYCLES - 1);
    localparam logic [WCNT_W-1:0] WCNT_LAST = WCNT_W'(WINDOW_COUNT - 1);
    localparam logic [HCNT_W-1:0] HCNT_LAST = HCNT_W'(HOLDOFF_COUNT - 1);
    localparam logic [NS_W-1:0]   NS_FULL   = NS_W'(SAMPLES_PER_WINDOW);

    typedef struct packed {
        margin_state_t     st;
        logic [15:0]       setup;
        logic [7:0]        drive;
        logic [PCNT_W-1:0] pcnt;
        logic [WCNT_W-1:0] wcnt;
        logic [SUM_W-1:0]  sum;
        logic [NS_W-1:0]   nsamp;
        logic              first;
        logic              ignored;
        logic [HCNT_W-1:0] hcnt;
        logic              holdoff;
        logic              monitor;
        logic              stat_margin;
        logic              mfault;
        logic              alert;
        logic              pulse;
        logic              pulse_oe;
        logic              dac_oe;
        logic              sink;
        logic [15:0]       rdata;
        logic              rvalid;
    } state_t;

    state_t cur_r;
    state_t cur_nxt;

    // Duty threshold in clock cycles for a given 8-bit drive
    function automatic logic [PCNT_W-1:0] duty_cycles(
        input logic [7:0] drv
    );
        logic [PCNT_W+8:0] prod;
        prod = (PCNT_W+9)'(drv) * (PCNT_W+9)'(PWM_PERIOD_CYCLES);
        return prod[PCNT_W+7:8];
    endfunction : duty_cycles

    // One-count step with clamping instead of wrapping
    function automatic logic [7:0] step_drive(
        input logic [7:0] drv,
        input logic       up
    );
        logic [7:0] res;
        res = drv;
        if (up && drv != DRIVE_MAX) begin
            res = drv + 8'h01;
        end else if (!up && drv != DRIVE_MIN) begin
            res = drv - 8'h01;
        end
        return res;
    endfunction : step_drive

    // Only the margin setup code is mapped; others read as zero
    function automatic logic setup_hit(
        input logic [7:0] code
    );
        return code == MARGIN_SETUP_CODE;
    endfunction : setup_hit

    // Drive already pinned at the rail the next step heads for
    function automatic logic rail_hit(
        input logic [7:0] drv,
        input logic       up
    );
        return up ? (drv == DRIVE_MAX) : (drv == DRIVE_MIN);
    endfunction : rail_hit

    logic              cmd_active;
    logic              want_high;
    logic [VOUT_W-1:0] avg;
    logic [VOUT_W-1:0] target;
    logic              below;
    logic              above;
    logic              raise_out;
    logic              step_up;
    logic              overshoot;
    logic              at_rail;
    logic              window_end;
    logic              fault_evt;
    logic [7:0]        start_drive;

    always_comb begin
        cmd_active  = (margin_cmd_in == CMD_HIGH)
                      || (margin_cmd_in == CMD_LOW);
        want_high   = (margin_cmd_in == CMD_HIGH);
        avg         = cur_r.sum[SUM_W-1:AVG_SHIFT];
        target      = want_high ? target_high_in : target_low_in;
        below       = avg < target;
        above       = avg > target;
        raise_out   = below;

        // Slope 0: more drive lowers the output
        step_up     = cur_r.setup[SLOPE_BIT] ? raise_out
                                             : !raise_out;
        overshoot   = want_high ? above
                                : below;
        // Rail reached and still short of target; covers a dead DAC link too
        at_rail     = rail_hit(cur_r.drive, step_up)
                      && (below || above);
        window_end  = (cur_r.wcnt == WCNT_LAST);
        start_drive = dac_page_in ? DAC_INITIAL_DRIVE
                                  : cur_r.setup[INIT_MSB:0];
        fault_evt   = 1'b0;
        cur_nxt     = cur_r;
        cur_nxt.rvalid = 1'b0;

        if (reg_wr_in && setup_hit(reg_code_in)) begin
            cur_nxt.setup = reg_wdata_in & SETUP_WRITE_MASK;
        end
        // Read data holds until the next read strobe
        if (reg_rd_in) begin
            cur_nxt.rvalid = 1'b1;
            cur_nxt.rdata  = setup_hit(reg_code_in)
                             ? (cur_r.setup & SETUP_WRITE_MASK)
                             : 16'h0000;
        end

        // Free-running period counter keeps the PWM frequency fixed
        cur_nxt.pcnt = (cur_r.pcnt == PCNT_LAST) ? '0
                       : cur_r.pcnt + PCNT_W'(1);

        unique case (cur_r.st)
            ST_IDLE: begin
                cur_nxt.pulse_oe = 1'b0;
                cur_nxt.dac_oe   = 1'b0;
                if (cmd_active) begin
                    cur_nxt.st      = ST_WAIT_PG;
                    cur_nxt.ignored = ignore_faults_in;
                end
            end
            ST_WAIT_PG: begin
                // Direction is set from the first wait cycle, no later than the edge that switches the outputs on
                cur_nxt.sink = want_high;
                if (!cmd_active) begin
                    cur_nxt.st = ST_IDLE;
                end else if (power_good_all_in) begin
                    cur_nxt.st       = ST_MARGIN;
                    cur_nxt.drive    = start_drive;
                    cur_nxt.pulse_oe = !dac_page_in;
                    cur_nxt.dac_oe   = dac_page_in;
                    cur_nxt.wcnt     = '0;
                    cur_nxt.sum      = '0;
                    cur_nxt.nsamp    = '0;
                    cur_nxt.first    = 1'b1;
                end
            end
            ST_MARGIN: begin
                cur_nxt.sink = want_high;
                // Ignore mode remembered until the holdoff has run out
                if (ignore_faults_in) begin
                    cur_nxt.ignored = 1'b1;
                end
                if (!cmd_active) begin
                    cur_nxt.st       = ST_IDLE;
                    cur_nxt.pulse_oe = 1'b0;
                    cur_nxt.dac_oe   = 1'b0;
                    if (cur_r.ignored) begin
                        cur_nxt.holdoff = 1'b1;
                        cur_nxt.hcnt    = '0;
                    end
                end else if (cur_r.setup[OPEN_LOOP_BIT]) begin
                    cur_nxt.drive = cur_r.setup[INIT_MSB:0];
                end else begin
                    cur_nxt.wcnt = window_end ? '0
                                   : cur_r.wcnt + WCNT_W'(1);
                    // Count caps at four; later strobes in a window drop
                    if (sample_valid_in && cur_r.nsamp != NS_FULL) begin
                        cur_nxt.sum   = cur_r.sum + SUM_W'(vout_sample_in);
                        cur_nxt.nsamp = cur_r.nsamp + NS_W'(1);
                    end
                    // Short windows are skipped rather than averaged wrong
                    if (window_end) begin
                        cur_nxt.sum   = '0;
                        cur_nxt.nsamp = '0;
                        if (cur_r.nsamp == NS_FULL) begin
                            cur_nxt.first = 1'b0;
                            if (cur_r.first && overshoot) begin
                                fault_evt = 1'b1;
                            end
                            if (at_rail) begin
                                fault_evt = 1'b1;
                            end
                            // Loop keeps stepping even after a fault
                            if (below || above) begin
                                cur_nxt.drive = step_drive(cur_r.drive,
                                                           step_up);
                            end
                        end
                    end
                end
            end
            default: begin
                cur_nxt.st = ST_IDLE;
            end
        endcase

        if (cur_r.holdoff) begin
            if (cur_r.hcnt == HCNT_LAST) begin
                cur_nxt.holdoff = 1'b0;
            end else begin
                cur_nxt.hcnt = cur_r.hcnt + HCNT_W'(1);
            end
        end
        // Own flop so the pin comes straight off a register
        cur_nxt.monitor = !cur_nxt.holdoff;

        if (cur_nxt.st == ST_IDLE && !cur_nxt.holdoff) begin
            cur_nxt.ignored = 1'b0;
        end

        // Next-cycle counter and drive keep the pin in step with its enable
        cur_nxt.pulse = cur_nxt.pulse_oe
                        && (cur_nxt.pcnt < duty_cycles(cur_nxt.drive));

        // Set wins over a clear in the same cycle
        if (status_clear_in) begin
            cur_nxt.stat_margin = 1'b0;
            cur_nxt.mfault      = 1'b0;
            cur_nxt.alert       = 1'b0;
        end
        if (fault_evt) begin
            cur_nxt.stat_margin = 1'b1;
            cur_nxt.mfault      = 1'b1;
            cur_nxt.alert       = cur_r.alert | alert_enable_in;
        end
    end

    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            cur_r       <= '0;
            cur_r.st    <= ST_IDLE;
            cur_r.setup <= MARGIN_SETUP_RESET;
            cur_r.monitor <= 1'b1;
        end else begin
            cur_r <= cur_nxt;
        end
    end

    always_comb begin
        reg_rdata_out     = cur_r.rdata;
        reg_rvalid_out    = cur_r.rvalid;
        margin_pulse_out  = cur_r.pulse;
        pulse_oe_out      = cur_r.pulse_oe;
        dac_value_out     = cur_r.drive;
        dac_oe_out        = cur_r.dac_oe;
        sink_current_out  = cur_r.sink;
        status_margin_out = cur_r.stat_margin;
        margin_fault_out  = cur_r.mfault;
        alert_out         = cur_r.alert;
        fault_monitor_out = cur_r.monitor;
    end

endmodule : supply_margining_controller

// >>> tb/margin_checker.sv
// Port-level assertions for the margining controller
`timescale 1ns/1ps
module margin_checker
    import margin_pkg::*;
#(
    parameter int HOLDOFF_COUNT = 30
) (
    input wire logic        clock_in,          // Clock
    input wire logic        rst_n_in,          // Reset, low
    input wire logic [1:0]  margin_cmd_in,     // Margin command
    input wire logic        dac_page_in,       // DAC page
    input wire logic        alert_enable_in,   // Alert enable
    input wire logic        status_clear_in,   // Flag clear
    input wire logic        power_good_all_in, // Power good
    input wire logic [15:0] reg_rdata_out,     // Read data
    input wire logic        reg_rvalid_out,    // Read valid
    input wire logic        pulse_oe_out,      // PWM enable
    input wire logic [7:0]  dac_value_out,     // Drive
    input wire logic        dac_oe_out,        // DAC enable
    input wire logic        sink_current_out,  // Sink select
    input wire logic        status_margin_out, // Status bit
    input wire logic        margin_fault_out,  // Fault flag
    input wire logic        alert_out,         // Alert
    input wire logic        fault_monitor_out  // Monitor on
);
    logic [31:0] low_cnt_r;
    logic        drv_on;
    assign drv_on = pulse_oe_out | dac_oe_out;
    // Counts the low stretch so the holdoff length is checked exactly
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in)
            low_cnt_r <= '0;
        else if (fault_monitor_out)
            low_cnt_r <= '0;
        else
            low_cnt_r <= low_cnt_r + 32'd1;
    end
    default clocking cb @(posedge clock_in); endclocking
    default disable iff (!rst_n_in);
    a_mid_zero: assert property (reg_rvalid_out |->
        reg_rdata_out[13:8] == 6'h00) else $error("middle bits not zero");
    a_idle_hiz: assert property ((margin_cmd_in == 2'h0)[*2] |=>
        !drv_on) else $error("output driven while idle");
    a_pg_gate: assert property ($rose(drv_on) |->
        $past(power_good_all_in)) else $error("enabled before power good");
    a_page_route: assert property (pulse_oe_out |->
        !dac_page_in && !dac_oe_out) else $error("wrong output enabled");
    a_one_count: assert property (drv_on && $past(drv_on) &&
        dac_value_out != $past(dac_value_out) |->
        dac_value_out == $past(dac_value_out) + 8'h01 ||
        dac_value_out == $past(dac_value_out) - 8'h01)
        else $error("drive moved by more than one");
    a_no_wrap: assert property (drv_on && $past(drv_on) |->
        !($past(dac_value_out) == 8'hFF && dac_value_out == 8'h00) &&
        !($past(dac_value_out) == 8'h00 && dac_value_out == 8'hFF))
        else $error("drive wrapped");
    a_sink_high: assert property ((margin_cmd_in == 2'h1)[*4] |->
        sink_current_out) else $error("not sinking on margin high");
    a_sink_low: assert property ((margin_cmd_in == 2'h2)[*4] |->
        !sink_current_out) else $error("not sourcing on margin low");
    a_fault_status: assert property ($rose(margin_fault_out) |->
        status_margin_out) else $error("fault without status bit");
    a_alert_gate: assert property ($rose(alert_out) |->
        $past(alert_enable_in)) else $error("alert while disabled");
    a_fault_sticky: assert property (margin_fault_out &&
        !status_clear_in |=> margin_fault_out) else $error("fault flag lost");
    a_holdoff_len: assert property ($rose(fault_monitor_out) |->
        low_cnt_r == HOLDOFF_COUNT) else $error("holdoff length wrong");
endmodule : margin_checker

bind supply_margining_controller margin_checker #(
    .HOLDOFF_COUNT(HOLDOFF_COUNT)) u_chk (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .margin_cmd_in(margin_cmd_in),
    .dac_page_in(dac_page_in), .alert_enable_in(alert_enable_in),
    .status_clear_in(status_clear_in), .power_good_all_in(power_good_all_in),
    .reg_rdata_out(reg_rdata_out), .reg_rvalid_out(reg_rvalid_out),
    .pulse_oe_out(pulse_oe_out), .dac_value_out(dac_value_out),
    .dac_oe_out(dac_oe_out), .sink_current_out(sink_current_out),
    .status_margin_out(status_margin_out), .alert_out(alert_out),
    .margin_fault_out(margin_fault_out),
    .fault_monitor_out(fault_monitor_out));

// >>> tb/supply_model.sv
// Behavioural supply whose output follows the margin drive value
`timescale 1ns/1ps
module supply_model (
    input  wire logic        clock_in,    // Clock
    input  wire logic        rst_n_in,    // Reset, low
    input  wire logic        drive_on_in, // PWM or DAC enabled
    input  wire logic        slope_in,    // 1 positive slope
    input  wire logic [7:0]  drive_in,    // Drive value
    output logic      [15:0] vout_out,    // Measured output
    output logic             valid_out    // Sample strobe
);
    logic [2:0] tick_r;
    // Released output shows a moving pattern, never a stale sample
    assign vout_out = !drive_on_in ? {8'hA5, 5'h00, tick_r} :
        slope_in ? 16'h1000 + {8'h00, drive_in} :
        16'h1000 - {8'h00, drive_in};
    always_ff @(posedge clock_in or negedge rst_n_in) begin
        if (!rst_n_in) begin
            tick_r <= 3'h0;
            valid_out <= 1'b0;
        end else begin
            tick_r <= tick_r + 3'h1;
            valid_out <= drive_on_in && tick_r == 3'h0;
        end
    end
endmodule : supply_model

// >>> tb/supply_margining_controller_tb_top.sv
// Self-checking bench for the supply margining controller
`timescale 1ns/1ps
module supply_margining_controller_tb_top;
    import margin_pkg::*;
    logic        clock_in, rst_n_in, reg_wr_in, reg_rd_in, slope;
    logic        ignore_faults_in, power_good_all_in, dac_page_in;
    logic        alert_enable_in, status_clear_in, sample_valid_in;
    logic        reg_rvalid_out, margin_pulse_out, pulse_oe_out, dac_oe_out;
    logic        sink_current_out, status_margin_out, margin_fault_out;
    logic        alert_out, fault_monitor_out;
    logic [1:0]  margin_cmd_in;
    logic [7:0]  reg_code_in, dac_value_out;
    logic [15:0] reg_wdata_in, vout_sample_in, target_in, reg_rdata_out;
    int          error_cnt, tests_run, cycles, hi_cnt;

    supply_margining_controller #(.WINDOW_COUNT(40), .HOLDOFF_COUNT(30)) dut (
        .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_wr_in(reg_wr_in),
        .reg_rd_in(reg_rd_in), .reg_code_in(reg_code_in),
        .reg_wdata_in(reg_wdata_in), .margin_cmd_in(margin_cmd_in),
        .ignore_faults_in(ignore_faults_in), .dac_page_in(dac_page_in),
        .power_good_all_in(power_good_all_in),
        .sample_valid_in(sample_valid_in),
        .vout_sample_in(vout_sample_in), .target_high_in(target_in),
        .target_low_in(target_in), .alert_enable_in(alert_enable_in),
        .status_clear_in(status_clear_in), .reg_rdata_out(reg_rdata_out),
        .reg_rvalid_out(reg_rvalid_out), .margin_pulse_out(margin_pulse_out),
        .pulse_oe_out(pulse_oe_out), .dac_value_out(dac_value_out),
        .dac_oe_out(dac_oe_out), .sink_current_out(sink_current_out),
        .status_margin_out(status_margin_out), .alert_out(alert_out),
        .margin_fault_out(margin_fault_out),
        .fault_monitor_out(fault_monitor_out));
    supply_model u_supply (.clock_in(clock_in), .rst_n_in(rst_n_in),
        .drive_on_in(pulse_oe_out | dac_oe_out), .slope_in(slope),
        .drive_in(dac_value_out), .vout_out(vout_sample_in),
        .valid_out(sample_valid_in));

    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, error_cnt);
        if (error_cnt == 0 && tests_run > 0)
            $display("DONE - PASS");
        else
            $display("DONE - FAIL");
        $finish;
    endtask : report_and_stop
    task chk(input string nm, input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            error_cnt++;
            $display("MISMATCH %s expected %h seen %h", nm, exp, seen);
        end
    endtask : chk
    task wr(input logic [7:0] code, input logic [15:0] data);
        @(posedge clock_in);
        reg_wr_in <= 1'b1;
        reg_code_in <= code;
        reg_wdata_in <= data;
        @(posedge clock_in);
        reg_wr_in <= 1'b0;
    endtask : wr
    task rd(input logic [7:0] code, input logic [15:0] exp, input string nm);
        @(posedge clock_in);
        reg_rd_in <= 1'b1;
        reg_code_in <= code;
        @(posedge clock_in);
        reg_rd_in <= 1'b0;
        #1 chk(nm, reg_rdata_out, exp);
        chk("rvalid", 16'(reg_rvalid_out), 16'h1);
    endtask : rd
    task run(input logic [1:0] cmd, input logic page, input logic slp,
             input logic [15:0] tgt, input int n);
        @(posedge clock_in);
        margin_cmd_in <= cmd;
        dac_page_in <= page;
        slope <= slp;
        target_in <= tgt;
        repeat (n) @(posedge clock_in);
        #1;
    endtask : run
    task stop_margin;
        @(posedge clock_in);
        margin_cmd_in <= 2'h0;
        repeat (3) @(posedge clock_in);
        #1 chk("enables", 16'({pulse_oe_out, dac_oe_out}), 16'h0);
    endtask : stop_margin

    initial begin
        clock_in = 1'b0;
        forever #2 clock_in = ~clock_in;
    end
    // Run takes about 2500 cycles
    always @(posedge clock_in) begin
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            error_cnt++;
            report_and_stop();
        end
    end

    initial begin
        {rst_n_in, reg_wr_in, reg_rd_in, slope, ignore_faults_in} = '0;
        {dac_page_in, alert_enable_in, status_clear_in, margin_cmd_in} = '0;
        {reg_code_in, reg_wdata_in, target_in} = '0;
        {error_cnt, tests_run, cycles} = '0;
        power_good_all_in = 1'b1;
        repeat (20) @(posedge clock_in);
        rst_n_in <= 1'b1;
        @(posedge clock_in);
        #1 chk("monitor", 16'(fault_monitor_out), 16'h1);
        rd(MARGIN_SETUP_CODE, 16'h0000, "setup reset");
        wr(MARGIN_SETUP_CODE, 16'hFFFF);
        rd(MARGIN_SETUP_CODE, 16'hC0FF, "setup mask");
        wr(8'h10, 16'h1234);
        rd(8'h10, 16'h0000, "unmapped");
        rd(MARGIN_SETUP_CODE, 16'hC0FF, "setup kept");
        wr(MARGIN_SETUP_CODE, 16'h4055);
        power_good_all_in <= 1'b0;
        run(2'h1, 1'b0, 1'b0, 16'h0F00, 6);
        chk("pg wait", 16'({pulse_oe_out, dac_oe_out}), 16'h0);
        power_good_all_in <= 1'b1;
        run(2'h1, 1'b0, 1'b0, 16'h0F00, 3);
        chk("open start", 16'({pulse_oe_out, dac_value_out}),
            16'h155);
        // One full PWM period of 800 cycles at drive 0x55 of 256
        hi_cnt = 0;
        repeat (800) begin
            @(posedge clock_in);
            #1 hi_cnt += margin_pulse_out;
        end
        chk("duty", 16'(hi_cnt), 16'h0109);
        run(2'h1, 1'b0, 1'b0, 16'h0F00, 300);
        chk("open hold", 16'(dac_value_out), 16'h55);
        chk("open fault", 16'(margin_fault_out), 16'h0);
        stop_margin();
        wr(MARGIN_SETUP_CODE, 16'h0080);
        run(2'h2, 1'b0, 1'b0, 16'h0F7C, 3);
        chk("loop start", 16'(dac_value_out), 16'h80);
        run(2'h2, 1'b0, 1'b0, 16'h0F7C, 400);
        chk("loop settle", 16'(dac_value_out), 16'h84);
        chk("loop fault", 16'(margin_fault_out), 16'h0);
        stop_margin();
        alert_enable_in <= 1'b1;
        run(2'h1, 1'b0, 1'b0, 16'h0F70, 60);
        chk("overshoot", 16'({status_margin_out, margin_fault_out, alert_out}),
            16'h7);
        run(2'h1, 1'b0, 1'b0, 16'h0F70, 800);
        chk("keep trying", 16'(dac_value_out), 16'h90);
        stop_margin();
        status_clear_in <= 1'b1;
        @(posedge clock_in);
        status_clear_in <= 1'b0;
        alert_enable_in <= 1'b0;
        @(posedge clock_in);
        #1 chk("cleared",
            16'({status_margin_out, margin_fault_out, alert_out}),
            16'h0);
        wr(MARGIN_SETUP_CODE, 16'h8033);
        run(2'h2, 1'b1, 1'b1, 16'h0F00, 3);
        chk("dac start", 16'({pulse_oe_out, dac_oe_out, dac_value_out}),
            16'h100);
        run(2'h2, 1'b1, 1'b1, 16'h0F00, 100);
        chk("rail fault", 16'({margin_fault_out, alert_out, dac_value_out}),
            16'h200);
        ignore_faults_in <= 1'b1;
        stop_margin();
        ignore_faults_in <= 1'b0;
        chk("holdoff", 16'(fault_monitor_out), 16'h0);
        repeat (40) @(posedge clock_in);
        #1 chk("monitor back", 16'(fault_monitor_out), 16'h1);
        report_and_stop();
    end
endmodule : supply_margining_controller_tb_top
